//--- logic/mss_cfg.svh
// constants of the multi-stage speed sequencer: offsets, fields, defaults
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH
// ==========================================================================
// register regions (byte address bits 9:6) and entries (bits 5:2)
`define MSS_REG_MISC 4'h0
`define MSS_REG_FREQ 4'h1
`define MSS_REG_ACCEL 4'h2
`define MSS_REG_DECEL 4'h3
`define MSS_REG_RUN 4'h4
`define MSS_REG_PAUSE 4'h5
`define MSS_MISC_CTRL 4'h0
`define MSS_MISC_CYCLE 4'h1
`define MSS_MISC_LIMITS 4'h2
`define MSS_MISC_DIR 4'h3
`define MSS_MISC_STATUS 4'h4
// ==========================================================================
// table sizes
`define MSS_NUM_STAGES 15
`define MSS_NUM_TIMED 8
// ==========================================================================
// setting codes
`define MSS_SRC_MULTISTAGE 4'h4
`define MSS_COMB_STAGE_FIRST 4'h4
`define MSS_TYPE_THREE 2'h0
`define MSS_TYPE_FIFTEEN 2'h1
`define MSS_TYPE_AUTO 2'h2
// ==========================================================================
// reset values and limits (frequency in 0.01 Hz, time in 0.1 s)
`define MSS_TYPE_DEFAULT 2'h1
`define MSS_STAGES_DEFAULT 4'h7
`define MSS_STAGES_MIN 4'h2
`define MSS_STAGES_MAX 4'h8
`define MSS_REPEAT_MAX 14'h270f
`define MSS_FREQ_STEP 16'h01f4
`define MSS_TIME_MIN 16'h0001
`define MSS_TIME_MAX 16'h7530
`define MSS_RUN_DEFAULT 16'h000a
`define MSS_MIN_FREQ_DEFAULT 16'h0000
`define MSS_MAX_FREQ_DEFAULT 16'h1388
`define MSS_RAMP_DEFAULT 16'h0064
// ==========================================================================
// clock and tick: 0.1 s resolution at a 100 ns clock
`define MSS_TICK_NS 100000000
`define MSS_CLOCK_NS 100
`endif

//--- logic/mss_pkg.sv
// types shared by the multi-stage speed sequencer modules
package mss_pkg;
  // ========================================================================
  // cycling sequencer states
  typedef enum logic [1:0] {
    MSS_IDLE,
    MSS_RUN,
    MSS_PAUSE,
    MSS_HOLD
  } mss_state_t;
  typedef logic [15:0] mss_word_t;
endpackage

//--- logic/mss_timer_if.sv
// load/tick/expiry bundle between the sequencer and one stage timer
`timescale 1ns/1ps
`default_nettype none
interface mss_timer_if;
  logic tick;
  logic load;
  logic [15:0] value;
  logic expired;
  modport owner(output tick, output load, output value, input expired);
  modport timer(input tick, input load, input value, output expired);
endinterface
`default_nettype wire

//--- logic/mss_tick_gen.sv
// divider giving one-cycle pulses every tenth of a second
`timescale 1ns/1ps
`default_nettype none
module mss_tick_gen import mss_pkg::*; #(
  parameter int TICK_CYCLES = 1000000
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  output logic tick // one-cycle pulse per period
);
  logic [31:0] count;
  // ==========================================================================
  // free-running divider; phase is not aligned to stage starts
  always_ff @(posedge clock) begin
    if (rst || count == 32'(TICK_CYCLES - 1)) begin
      count <= 32'h0000_0000;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end
  always_ff @(posedge clock) begin
    tick <= !rst && (count == 32'(TICK_CYCLES - 1));
  end
endmodule
`default_nettype wire

//--- logic/mss_stage_timer.sv
// down counter of tenths of a second for run and pause times
`timescale 1ns/1ps
`default_nettype none
module mss_stage_timer import mss_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  mss_timer_if.timer tif // load, value, tick, expiry
);
  logic [WIDTH-1:0] remain;
  // ==========================================================================
  // load wins over the tick so a fresh stage never loses a count
  always_ff @(posedge clock) begin
    if (rst) begin
      remain <= '0;
    end else if (tif.load) begin
      remain <= WIDTH'(tif.value);
    end else if (tif.tick && remain != '0) begin
      remain <= remain - 1'b1;
    end
  end
  assign tif.expired = (remain == '0);
endmodule
`default_nettype wire

//--- logic/mss_sequencer.sv
// multi-stage speed selector and auto-cycling sequencer with Avalon-MM registers
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"
module mss_sequencer import mss_pkg::*; #(
  parameter int TICK_CYCLES = (`MSS_TICK_NS + `MSS_CLOCK_NS - 1) / `MSS_CLOCK_NS,
  parameter logic [15:0] RAMP_DEFAULT = `MSS_RAMP_DEFAULT
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [9:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall until answer
  input wire logic run_cmd_pin, // run command, keypad or terminal
  input wire logic stop_key_pin, // keypad stop key
  input wire logic stop_term_pin, // stop terminal
  input wire logic [3:0] stage_sel_pin, // stage select terminals
  input wire logic flycatch_busy, // speed tracking catch in progress
  input wire logic [15:0] analog_ref, // analog frequency reference
  output logic drive_run, // drive to run
  output logic [15:0] target_freq, // target frequency, 0.01 Hz
  output logic drive_reverse, // reverse direction
  output logic [15:0] accel_time, // acceleration time, 0.1 s
  output logic [15:0] decel_time, // deceleration time, 0.1 s
  output logic [3:0] active_stage, // stage number 1..15, 0 for none
  output logic seq_running // cycling sequencer busy
);
  // ==========================================================================
  // settings
  logic [1:0] stage_speed_type;
  logic post_cycle_action;
  logic [3:0] main_frequency_source;
  logic [3:0] source_combination_select;
  logic [3:0] cycle_stage_count;
  logic [13:0] cycle_repeat_count;
  logic [15:0] min_frequency_limit;
  logic [15:0] max_frequency_limit;
  logic [14:0] stage_directions; // low 8 then high 7
  mss_word_t stage_frequency_table [`MSS_NUM_STAGES];
  mss_word_t stage_accel_times [`MSS_NUM_STAGES];
  mss_word_t stage_decel_times [`MSS_NUM_STAGES];
  mss_word_t stage_run_times [`MSS_NUM_TIMED];
  mss_word_t stage_pause_times [`MSS_NUM_TIMED];
  // sequencer state
  mss_state_t state, next_state;
  logic [2:0] seq_stage, next_stage;
  logic [13:0] cycles_done, next_done;
  logic run_latch;
  logic next_run_latch;
  // ==========================================================================
  // pin synchronisers: stage 1 is read only by stage 2
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic run_prev;
  always_ff @(posedge clock) begin
    pin_meta <= {stage_sel_pin, stop_term_pin, stop_key_pin, run_cmd_pin};
    pin_sync <= pin_meta;
    run_prev <= rst ? 1'b0 : pin_sync[0];
  end
  logic run_ev;
  logic stop_ev;
  logic [3:0] sel_sync;
  assign run_ev = pin_sync[0] && !run_prev;
  assign stop_ev = pin_sync[1] || pin_sync[2];
  assign sel_sync = pin_sync[6:3];
  // ==========================================================================
  // mode decode
  logic seq_enable;
  logic auto_on;
  assign seq_enable = (main_frequency_source == `MSS_SRC_MULTISTAGE);
  assign auto_on = seq_enable && (stage_speed_type == `MSS_TYPE_AUTO);
  // manual stage selection: priority in three-stage, code in fifteen-stage
  logic [3:0] manual_idx;
  logic manual_hit;
  always_comb begin
    manual_idx = 4'h0;
    manual_hit = 1'b0;
    if (stage_speed_type == `MSS_TYPE_THREE) begin
      manual_hit = |sel_sync[2:0];
      if (sel_sync[0]) begin
        manual_idx = 4'h0;
      end else if (sel_sync[1]) begin
        manual_idx = 4'h1;
      end else begin
        manual_idx = 4'h2;
      end
    end else if (stage_speed_type == `MSS_TYPE_FIFTEEN) begin
      manual_hit = (sel_sync != 4'h0);
      manual_idx = sel_sync - 4'h1;
    end
  end
  // ==========================================================================
  // stage selection and limit clamp
  logic [3:0] stage_idx;
  logic use_stage;
  logic [15:0] raw_freq;
  logic [15:0] clamped_freq;
  logic [15:0] sel_freq;
  assign stage_idx = auto_on ? {1'b0, seq_stage} : manual_idx;
  // outside cycling, analog wins unless combination is 4 or no analog reference is given
  assign use_stage = auto_on || (seq_enable && manual_hit &&
    (source_combination_select == `MSS_COMB_STAGE_FIRST || analog_ref == 16'h0000));
  assign raw_freq = stage_frequency_table[stage_idx];
  assign clamped_freq = (raw_freq < min_frequency_limit) ? min_frequency_limit :
    (raw_freq > max_frequency_limit) ? max_frequency_limit : raw_freq;
  // in cycling the analog reference is never consulted
  assign sel_freq = use_stage ? clamped_freq : analog_ref;
  // ==========================================================================
  // timers: one tick source shared by run and pause counters
  logic tick;
  mss_timer_if run_tif();
  mss_timer_if pause_tif();
  mss_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );
  mss_stage_timer #(.WIDTH(16)) u_run_timer (
    .clock(clock),
    .rst(rst),
    .tif(run_tif)
  );
  mss_stage_timer #(.WIDTH(16)) u_pause_timer (
    .clock(clock),
    .rst(rst),
    .tif(pause_tif)
  );
  assign run_tif.tick = tick;
  assign pause_tif.tick = tick;
  // ==========================================================================
  // cycling state machine
  logic last_stage;
  logic [13:0] done_inc;
  assign last_stage = (seq_stage == 3'(cycle_stage_count - 4'h1));
  assign done_inc = cycles_done + 14'h0001;
  always_comb begin
    next_state = state;
    next_stage = seq_stage;
    next_done = cycles_done;
    run_tif.load = 1'b0;
    run_tif.value = stage_run_times[0];
    pause_tif.load = 1'b0;
    pause_tif.value = stage_pause_times[seq_stage];
    if (!auto_on || stop_ev) begin
      next_state = MSS_IDLE;
    end else if (!flycatch_busy) begin
      unique case (state)
        MSS_IDLE: begin
          if (run_ev) begin
            next_state = MSS_RUN;
            next_stage = 3'h0;
            next_done = 14'h0000;
            run_tif.load = 1'b1;
          end
        end
        MSS_RUN: begin
          if (run_tif.expired) begin
            next_state = MSS_PAUSE;
            pause_tif.load = 1'b1;
          end
        end
        MSS_PAUSE: begin
          if (pause_tif.expired && run_tif.expired) begin
            if (last_stage) begin
              next_done = done_inc;
              if (cycle_repeat_count != 14'h0000 && done_inc == cycle_repeat_count) begin
                next_state = post_cycle_action ? MSS_HOLD : MSS_IDLE;
              end else begin
                next_state = MSS_RUN;
                next_stage = 3'h0;
                run_tif.load = 1'b1;
              end
            end else begin
              next_state = MSS_RUN;
              next_stage = seq_stage + 3'h1;
              run_tif.value = stage_run_times[seq_stage + 3'h1];
              run_tif.load = 1'b1;
            end
          end
        end
        MSS_HOLD: begin
          next_state = MSS_HOLD;
        end
      endcase
    end
  end
  // manual modes run from a latch set by run and cleared by stop
  assign next_run_latch = stop_ev ? 1'b0 : (run_ev ? 1'b1 : run_latch);
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= MSS_IDLE;
      seq_stage <= 3'h0;
      cycles_done <= 14'h0000;
      run_latch <= 1'b0;
    end else begin
      state <= next_state;
      seq_stage <= next_stage;
      cycles_done <= next_done;
      run_latch <= next_run_latch;
    end
  end
  // ==========================================================================
  // drive outputs; frozen while a catch is running so the ramp keeps its goal
  logic next_drive_run;
  assign next_drive_run = auto_on ? (next_state == MSS_RUN || next_state == MSS_HOLD)
    : run_latch;
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_run <= 1'b0;
      target_freq <= 16'h0000;
      drive_reverse <= 1'b0;
      accel_time <= RAMP_DEFAULT;
      decel_time <= RAMP_DEFAULT;
      active_stage <= 4'h0;
      seq_running <= 1'b0;
    end else if (!flycatch_busy) begin
      drive_run <= next_drive_run;
      target_freq <= sel_freq;
      drive_reverse <= use_stage && stage_directions[stage_idx];
      accel_time <= use_stage ? stage_accel_times[stage_idx] : RAMP_DEFAULT;
      decel_time <= use_stage ? stage_decel_times[stage_idx] : RAMP_DEFAULT;
      active_stage <= use_stage ? stage_idx + 4'h1 : 4'h0;
      seq_running <= (next_state != MSS_IDLE);
    end
  end
  // ==========================================================================
  // Avalon-MM decode: one wait cycle, write lands when waitrequest is low
  logic [3:0] region;
  logic [3:0] entry;
  logic bus_req;
  logic wr_fire;
  logic entry_ok15;
  logic entry_ok8;
  logic [15:0] wd_lo;
  logic [15:0] wd_time;
  logic [15:0] wd_pause;
  logic [3:0] wd_stages;
  logic [31:0] rd_word;
  assign region = avs_address[9:6];
  assign entry = avs_address[5:2];
  assign bus_req = avs_read || avs_write;
  assign wr_fire = avs_write && !avs_waitrequest;
  assign entry_ok15 = (entry < 4'(`MSS_NUM_STAGES));
  assign entry_ok8 = (entry < 4'(`MSS_NUM_TIMED));
  assign wd_lo = avs_writedata[15:0];
  // out-of-range settings are pulled to the nearest legal value
  assign wd_time = (wd_lo < `MSS_TIME_MIN) ? `MSS_TIME_MIN :
    (wd_lo > `MSS_TIME_MAX) ? `MSS_TIME_MAX : wd_lo;
  assign wd_pause = (wd_lo > `MSS_TIME_MAX) ? `MSS_TIME_MAX : wd_lo;
  assign wd_stages = (avs_writedata[3:0] < `MSS_STAGES_MIN) ? `MSS_STAGES_MIN :
    (avs_writedata[3:0] > `MSS_STAGES_MAX) ? `MSS_STAGES_MAX : avs_writedata[3:0];
  // read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (region)
      `MSS_REG_MISC: begin
        unique case (entry)
          `MSS_MISC_CTRL: rd_word = {16'h0000, source_combination_select,
            main_frequency_source, 3'h0, post_cycle_action, 2'h0, stage_speed_type};
          `MSS_MISC_CYCLE: rd_word = {2'h0, cycle_repeat_count, 12'h000, cycle_stage_count};
          `MSS_MISC_LIMITS: rd_word = {max_frequency_limit, min_frequency_limit};
          `MSS_MISC_DIR: rd_word = {17'h0_0000, stage_directions};
          `MSS_MISC_STATUS: rd_word = {2'h0, cycles_done, 7'h00, seq_running,
            1'b0, seq_stage, 2'h0, state};
          default: rd_word = 32'h0000_0000;
        endcase
      end
      `MSS_REG_FREQ: rd_word = entry_ok15 ? {16'h0000, stage_frequency_table[entry]} : '0;
      `MSS_REG_ACCEL: rd_word = entry_ok15 ? {16'h0000, stage_accel_times[entry]} : '0;
      `MSS_REG_DECEL: rd_word = entry_ok15 ? {16'h0000, stage_decel_times[entry]} : '0;
      `MSS_REG_RUN: rd_word = entry_ok8 ? {16'h0000, stage_run_times[entry[2:0]]} : '0;
      `MSS_REG_PAUSE: rd_word = entry_ok8 ? {16'h0000, stage_pause_times[entry[2:0]]} : '0;
      default: rd_word = 32'h0000_0000;
    endcase
  end
  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      avs_readdata <= rd_word;
    end
  end
  // ==========================================================================
  // scalar settings
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_speed_type <= `MSS_TYPE_DEFAULT;
      post_cycle_action <= 1'b0;
      main_frequency_source <= 4'h0;
      source_combination_select <= 4'h0;
      cycle_stage_count <= `MSS_STAGES_DEFAULT;
      cycle_repeat_count <= 14'h0000;
      min_frequency_limit <= `MSS_MIN_FREQ_DEFAULT;
      max_frequency_limit <= `MSS_MAX_FREQ_DEFAULT;
      stage_directions <= 15'h0000;
    end else if (wr_fire && region == `MSS_REG_MISC) begin
      if (entry == `MSS_MISC_CTRL) begin
        stage_speed_type <= avs_writedata[1:0];
        post_cycle_action <= avs_writedata[4];
        main_frequency_source <= avs_writedata[11:8];
        source_combination_select <= avs_writedata[15:12];
      end
      if (entry == `MSS_MISC_CYCLE) begin
        cycle_stage_count <= wd_stages;
        cycle_repeat_count <= (avs_writedata[29:16] > `MSS_REPEAT_MAX) ?
          `MSS_REPEAT_MAX : avs_writedata[29:16];
      end
      if (entry == `MSS_MISC_LIMITS) begin
        min_frequency_limit <= avs_writedata[15:0];
        max_frequency_limit <= avs_writedata[31:16];
      end
      if (entry == `MSS_MISC_DIR) begin
        stage_directions <= avs_writedata[14:0];
      end
    end
  end
  // ==========================================================================
  // stage tables; frequency defaults step by 5 Hz, restarting at stage 9
  genvar gi;
  generate
    for (gi = 0; gi < `MSS_NUM_STAGES; gi++) begin : g_stage
      localparam logic [15:0] FREQ_DEF = (gi < `MSS_NUM_TIMED) ?
        16'((gi + 1) * `MSS_FREQ_STEP) : 16'((gi - `MSS_NUM_TIMED + 1) * `MSS_FREQ_STEP);
      logic hit;
      assign hit = wr_fire && entry == 4'(gi);
      always_ff @(posedge clock) begin
        if (rst) begin
          stage_frequency_table[gi] <= FREQ_DEF;
          stage_accel_times[gi] <= RAMP_DEFAULT;
          stage_decel_times[gi] <= RAMP_DEFAULT;
        end else begin
          if (hit && region == `MSS_REG_FREQ) stage_frequency_table[gi] <= wd_lo;
          if (hit && region == `MSS_REG_ACCEL) stage_accel_times[gi] <= wd_time;
          if (hit && region == `MSS_REG_DECEL) stage_decel_times[gi] <= wd_time;
        end
      end
      if (gi < `MSS_NUM_TIMED) begin : g_timed
        always_ff @(posedge clock) begin
          if (rst) begin
            stage_run_times[gi] <= `MSS_RUN_DEFAULT;
            stage_pause_times[gi] <= 16'h0000;
          end else begin
            if (hit && region == `MSS_REG_RUN) stage_run_times[gi] <= wd_time;
            if (hit && region == `MSS_REG_PAUSE) stage_pause_times[gi] <= wd_pause;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- testbench/mss_sequencer_props.sv
// checker for the sequencer's bus and drive ports
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_props (
  input wire logic clock, // clock
  input wire logic rst, // reset
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic avs_waitrequest, // stall
  input wire logic stop_key_pin, // key stop
  input wire logic stop_term_pin, // term stop
  input wire logic flycatch_busy, // catch
  input wire logic drive_run, // run
  input wire logic [15:0] target_freq, // freq
  input wire logic drive_reverse, // dir
  input wire logic [15:0] accel_time, // accel
  input wire logic [15:0] decel_time, // decel
  input wire logic [3:0] active_stage, // stage
  input wire logic seq_running // busy
);
  // ==========
  // bus handshake: one answer cycle per request
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans) else $error("request not answered");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  a_no_spurious: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  // ==========
  // reset, stop and catch; stop crosses a 2-flop sync, so six edges are allowed
  a_reset_state: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !drive_run
    && target_freq == 16'h0000 && active_stage == 4'h0 && !seq_running) else $error("bad reset");
  a_key_stop: assert property (
    (stop_key_pin && !flycatch_busy) [*6] |-> !drive_run && !seq_running)
    else $error("key stop ignored");
  a_term_stop: assert property (
    (stop_term_pin && !flycatch_busy) [*6] |-> !drive_run && !seq_running)
    else $error("terminal stop ignored");
  a_catch_freeze: assert property (
    flycatch_busy |=> $stable(target_freq) && $stable(drive_run) && $stable(active_stage))
    else $error("outputs moved during catch");
  a_catch_ramps: assert property (
    flycatch_busy |=> $stable({accel_time, decel_time, drive_reverse}))
    else $error("ramp outputs moved during catch");
endmodule
bind mss_sequencer mss_sequencer_props mss_sequencer_props_inst (
  .clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .stop_key_pin(stop_key_pin),
  .stop_term_pin(stop_term_pin), .flycatch_busy(flycatch_busy), .drive_run(drive_run),
  .target_freq(target_freq), .drive_reverse(drive_reverse), .accel_time(accel_time),
  .decel_time(decel_time), .active_stage(active_stage), .seq_running(seq_running));
`default_nettype wire

//--- testbench/mss_cmd_model.sv
// run and stop command sources standing at the sequencer's pins
`timescale 1ns/1ps
`default_nettype none
module mss_cmd_model (
  input wire logic clock, // system clock
  input wire logic run_req, // one-cycle run request
  input wire logic key_req, // hold keypad stop
  input wire logic term_req, // hold stop terminal
  output logic run_cmd_pin = 1'b0, // run pin
  output logic stop_key_pin = 1'b0, // keypad stop pin
  output logic stop_term_pin = 1'b0 // stop terminal pin
);
  logic [2:0] hold_cnt = 3'h0;
  // stretch run so the pin synchroniser cannot miss it
  always @(posedge clock) begin
    if (run_req) begin
      hold_cnt <= 3'h4;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end
  end
  // stop is a level; either source may raise it
  always @(posedge clock) begin
    run_cmd_pin <= run_req || (hold_cnt > 3'h1);
    stop_key_pin <= key_req;
    stop_term_pin <= term_req;
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench of the multi-stage speed sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, flycatch_busy = 1'b0;
  logic run_req = 1'b0, key_req = 1'b0, term_req = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] stage_sel_pin = 4'h0;
  logic [15:0] analog_ref = 16'h0123;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, run_cmd_pin, stop_key_pin, stop_term_pin;
  logic drive_run, drive_reverse, seq_running;
  logic [15:0] target_freq, accel_time, decel_time;
  logic [3:0] active_stage, s;
  int err_count = 0;
  int n_compared = 0;
  // defaults: ctrl, cycle, dir, status, freq 1/8/9/15, accel 1, run 1, pause 1, unmapped
  logic [9:0] dadr [12] = '{10'h000, 10'h004, 10'h00c, 10'h010, 10'h040, 10'h05c, 10'h060,
    10'h078, 10'h080, 10'h100, 10'h140, 10'h3fc};
  logic [15:0] dexp [12] = '{16'h0001, 16'h0007, 16'h0000, 16'h0000, 16'h01f4, 16'h0fa0,
    16'h01f4, 16'h0dac, 16'h0064, 16'h000a, 16'h0000, 16'h0000};
  // manual modes: ctrl word, select pins, stage shown, target
  logic [15:0] mctl [7] = '{16'h4400, 16'h4400, 16'h4400, 16'h4401, 16'h4401, 16'h0401, 16'h0001};
  logic [3:0] msel [7] = '{4'h7, 4'h6, 4'h4, 4'hf, 4'h9, 4'hf, 4'h0};
  logic [3:0] mstg [7] = '{4'h1, 4'h2, 4'h3, 4'hf, 4'h9, 4'h0, 4'h0};
  logic [15:0] mfrq [7] = '{16'h01f4, 16'h03e8, 16'h05dc, 16'h0dac, 16'h01f4, 16'h0123, 16'h0123};
  initial begin
    forever #50 clock = ~clock;
  end
  mss_cmd_model mss_cmd_model_inst (.clock(clock), .run_req(run_req), .key_req(key_req),
    .term_req(term_req), .run_cmd_pin(run_cmd_pin), .stop_key_pin(stop_key_pin),
    .stop_term_pin(stop_term_pin));
  mss_sequencer #(.TICK_CYCLES(4)) mss_sequencer_inst (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_cmd_pin(run_cmd_pin), .stop_key_pin(stop_key_pin),
    .stop_term_pin(stop_term_pin), .stage_sel_pin(stage_sel_pin), .flycatch_busy(flycatch_busy),
    .analog_ref(analog_ref), .drive_run(drive_run), .target_freq(target_freq),
    .drive_reverse(drive_reverse), .accel_time(accel_time), .decel_time(decel_time),
    .active_stage(active_stage), .seq_running(seq_running));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus cycles hold the request until waitrequest is seen low
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    chk(avs_readdata, e);
    avs_read <= 1'b0;
  endtask
  task automatic run_pulse;
    repeat (4) @(posedge clock);
    run_req <= 1'b1;
    @(posedge clock);
    run_req <= 1'b0;
  endtask
  task automatic wait_stage(input logic [3:0] t);
    // idle cycling already shows stage 1, so also wait for the drive to run
    for (int k = 0; k < 400 && {drive_run, active_stage} !== {1'b1, t}; k++) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wr(10'h3fc, 32'h0000_ffff);
    for (int i = 0; i < 12; i++) rd(dadr[i], {16'h0000, dexp[i]});
    wr(10'h004, 32'h2710_0009);
    rd(10'h004, 32'h270f_0008);
    wr(10'h004, 32'h0000_0001);
    rd(10'h004, 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      wr(10'h000, {16'h0000, mctl[i]});
      stage_sel_pin <= msel[i];
      repeat (8) @(posedge clock);
      chk(32'({active_stage, target_freq}), 32'({mstg[i], mfrq[i]}));
    end
    // analog source: drive follows the latched run command
    run_pulse();
    repeat (8) @(posedge clock);
    chk(32'(drive_run), 32'h0000_0001);
    // two stages, one cycle, stage 2 reversed with its own ramps
    wr(10'h004, 32'h0001_0002);
    wr(10'h00c, 32'h0000_0002);
    wr(10'h084, 32'h0000_0033);
    wr(10'h0c4, 32'h0000_0044);
    wr(10'h000, 32'h0000_0402);
    run_pulse();
    wait_stage(4'h1);
    chk(32'({drive_run, drive_reverse, target_freq}), 32'h0002_01f4);
    chk(32'({accel_time, decel_time}), 32'h0064_0064);
    wait_stage(4'h2);
    chk(32'({drive_run, drive_reverse, target_freq}), 32'h0003_03e8);
    chk(32'({accel_time, decel_time}), 32'h0033_0044);
    for (int k = 0; k < 400 && seq_running !== 1'b0; k++) @(posedge clock);
    repeat (2) @(posedge clock);
    chk(32'({seq_running, drive_run}), 32'h0000_0000);
    wr(10'h000, 32'h0000_0412);
    run_pulse();
    repeat (300) @(posedge clock);
    chk(32'({seq_running, drive_run, active_stage}), 32'h0000_0032);
    key_req <= 1'b1;
    repeat (10) @(posedge clock);
    chk(32'({seq_running, drive_run}), 32'h0000_0000);
    key_req <= 1'b0;
    // endless cycling, frozen by a catch, stopped and restarted
    wr(10'h004, 32'h0000_0002);
    wr(10'h000, 32'h0000_0402);
    run_pulse();
    repeat (300) @(posedge clock);
    chk(32'(seq_running), 32'h0000_0001);
    flycatch_busy <= 1'b1;
    @(posedge clock);
    s = active_stage;
    repeat (100) @(posedge clock);
    chk(32'(active_stage), 32'(s));
    flycatch_busy <= 1'b0;
    term_req <= 1'b1;
    repeat (10) @(posedge clock);
    chk(32'({seq_running, drive_run}), 32'h0000_0000);
    term_req <= 1'b0;
    run_pulse();
    repeat (10) @(posedge clock);
    chk(32'({seq_running, active_stage}), 32'h0000_0011);
    rd(10'h010, 32'h0000_0101);
    wrap_up();
  end
endmodule
`default_nettype wire
